// ==== core/fpsr_consts.svh ====
/*
  Constants for the FIFO partition and soft reset block: register map, field layout,
  reset values, buffer sizes and timing counts. Assumes a 100 MHz system clock.
*/
`ifndef FPSR_CONSTS_SVH
`define FPSR_CONSTS_SVH

`define FPSR_REG_INT_STS 8'h58
`define FPSR_REG_INT_EN 8'h5C
`define FPSR_REG_HARDWARE_CONFIGURATION 8'h74
`define FPSR_REG_RX_INF 8'h7C
`define FPSR_REG_TX_INF 8'h80
`define FPSR_REG_DROP 8'hA0
`define FPSR_REG_MAC_CTL 8'hA4

`define FPSR_HWC_SEL_LSB 16
`define FPSR_HWC_SEL_MSB 19
`define FPSR_HWC_STRAP 2
`define FPSR_HWC_TIMEOUT 1
`define FPSR_HWC_SOFTWARE_RESET_REQUEST 0
`define FPSR_INF_HI_LSB 16
`define FPSR_INF_HI_MSB 23

`define FPSR_INT_RXDROP 0
`define FPSR_INT_SRSTTO 1
`define FPSR_INT_RXSTS 2
`define FPSR_INT_TXSTS 3
`define FPSR_INT_W 4

`define FPSR_SEL_MIN 4'h2
`define FPSR_SEL_MAX 4'hE
`define FPSR_SEL_RST 4'h5
`define FPSR_MACCTL_RST 2'h0
`define FPSR_MACCTL_RXEN 0
`define FPSR_MACCTL_TXEN 1

`define FPSR_LVL_W 16
`define FPSR_BUF_BYTES 16'h4000
`define FPSR_TXS_BYTES 16'h0200
`define FPSR_TXS_DW 16'h0080
`define FPSR_RX_FULL_MARGIN 16'h0010
`define FPSR_TXM_BYTES 16'h0800
`define FPSR_RXM_BYTES 16'h0080
`define FPSR_DW_BYTES 16'h0004

`define FPSR_CLK_PERIOD_NS 10
`define FPSR_SOFTWARE_RESET_REQUEST_TIMEOUT_NS 10000
`define FPSR_SOFTWARE_RESET_REQUEST_MIN_NS 100
`define FPSR_PHY_IDLE_NS 400
`define FPSR_SOFTWARE_RESET_REQUEST_TIMEOUT_CYC (`FPSR_SOFTWARE_RESET_REQUEST_TIMEOUT_NS / `FPSR_CLK_PERIOD_NS)
`define FPSR_SOFTWARE_RESET_REQUEST_MIN_CYC ((`FPSR_SOFTWARE_RESET_REQUEST_MIN_NS + `FPSR_CLK_PERIOD_NS - 1) / `FPSR_CLK_PERIOD_NS)
`define FPSR_PHY_IDLE_CYC (`FPSR_PHY_IDLE_NS / `FPSR_CLK_PERIOD_NS)

`endif

// ==== core/fpsr_pkg.sv ====
/*
  Types shared by the FIFO partition block.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package fpsr_pkg;
  typedef logic [31:0] fpsr_word_t;
  typedef logic [7:0] fpsr_addr_t;
  typedef logic [15:0] fpsr_lvl_t;
  typedef enum logic [0:0] {
    SOFTWARE_RESET_REQUEST_IDLE,
    SOFTWARE_RESET_REQUEST_WAIT
  } fpsr_software_reset_request_state_t;
endpackage
`default_nettype wire

// ==== core/fpsr_lvl_if.sv ====
/*
  Handshake between the block and one occupancy counter.
  Assumes one controller and one counter on the same clock.
*/
`default_nettype none
interface fpsr_lvl_if;
  logic inc;
  logic dec;
  logic clr;
  fpsr_pkg::fpsr_lvl_t level;
  modport ctrl (output inc, output dec, output clr, input level);
  modport cnt (input inc, input dec, input clr, output level);
endinterface
`default_nettype wire

// ==== core/fpsr_level.sv ====
/*
  Occupancy counter of one FIFO or staging buffer, moving in fixed steps.
  Assumes the controller only raises dec when the level covers one step.
*/
`default_nettype none
module fpsr_level #(
  parameter fpsr_pkg::fpsr_lvl_t STEP = 16'h0001
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controller side
  fpsr_lvl_if.cnt lvl
);
  import fpsr_pkg::*;
  fpsr_lvl_t level_q;
  fpsr_lvl_t level_d;

  always_comb begin
    level_d = level_q;
    if (lvl.inc) begin
      level_d = level_d + STEP;
    end
    if (lvl.dec) begin
      level_d = level_d - STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || lvl.clr) begin
      level_q <= 16'h0000;
    end else begin
      level_q <= level_d;
    end
  end

  assign lvl.level = level_q;
endmodule
`default_nettype wire

// ==== core/fpsr_sync.sv ====
/*
  Two-flop synchronisers, one per bit.
  Assumes inputs are asynchronous levels; only the second flop is visible.
*/
`default_nettype none
module fpsr_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= async_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// ==== core/fpsr_top.sv ====
/*
  Shared 16 KB buffer partition model: occupancy of transmit and receive data and status
  FIFOs, fixed staging buffers toward the MAC, receive overrun dropping, hardware
  configuration register with soft reset. Levels are tracked, payload is not stored.
  Assumes a single-cycle register port and MAC strobes on SYS_CLK_I; PHY clocks and strap
  arrive from pins.
*/
// The register addresses and strobed register access are this design's own decisions.
`include "fpsr_consts.svh"
`default_nettype none
module fpsr_top (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire fpsr_pkg::fpsr_addr_t ADDR_I,
  input wire fpsr_pkg::fpsr_word_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output fpsr_pkg::fpsr_word_t RDATA_O,
  // Host FIFO strobes, one dword each
  input wire logic HOST_TXD_WR_I,
  input wire logic HOST_TXS_RD_I,
  input wire logic HOST_RXD_RD_I,
  input wire logic HOST_RXS_RD_I,
  // MAC side
  input wire logic MAC_TX_RD_I,
  input wire logic MAC_TX_STS_I,
  input wire logic MAC_RX_WR_I,
  input wire logic MAC_RX_EOF_I,
  output logic MAC_TX_VALID_O,
  // Pins
  input wire logic PHY_RX_CLK_I,
  input wire logic PHY_TX_CLK_I,
  input wire logic BUS_WIDTH_STRAP_I,
  // Status
  output logic RX_FULL_O,
  output logic IRQ_O
);
  import fpsr_pkg::*;

  fpsr_lvl_if txd_lvl ();
  fpsr_lvl_if txs_lvl ();
  fpsr_lvl_if txm_lvl ();
  fpsr_lvl_if rxd_lvl ();
  fpsr_lvl_if rxs_lvl ();
  fpsr_lvl_if rxm_lvl ();

  fpsr_level #(.STEP(`FPSR_DW_BYTES)) u_txd (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(txd_lvl));
  fpsr_level #(.STEP(16'h0001)) u_txs (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(txs_lvl));
  fpsr_level #(.STEP(`FPSR_DW_BYTES)) u_txm (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(txm_lvl));
  fpsr_level #(.STEP(`FPSR_DW_BYTES)) u_rxd (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(rxd_lvl));
  fpsr_level #(.STEP(16'h0001)) u_rxs (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(rxs_lvl));
  fpsr_level #(.STEP(`FPSR_DW_BYTES)) u_rxm (.clk_i(SYS_CLK_I), .rst_i(RST_I), .lvl(rxm_lvl));

  logic [2:0] pin_sync;
  fpsr_sync #(.W(3)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .async_i({BUS_WIDTH_STRAP_I, PHY_TX_CLK_I, PHY_RX_CLK_I}),
    .sync_o(pin_sync)
  );

  logic [3:0] sel_q;
  logic [1:0] mac_ctl_q;
  logic [`FPSR_INT_W-1:0] int_sts_q;
  logic [`FPSR_INT_W-1:0] int_en_q;
  logic [15:0] drop_cnt_q;
  logic timeout_flag_q;
  logic strap_q;
  logic [1:0] strap_wait_q;
  logic armed_q;
  logic dropping_q;
  logic frame_lost_q;
  logic sof_q;
  fpsr_software_reset_request_state_t software_reset_request_state_q;
  logic [11:0] software_reset_request_cnt_q;
  logic [1:0] clk_prev_q;
  logic [5:0] idle_cnt_q [2];

  fpsr_lvl_t tx_total;
  fpsr_lvl_t txd_size;
  fpsr_lvl_t txd_free;
  fpsr_lvl_t rx_total;
  fpsr_lvl_t rxs_size;
  fpsr_lvl_t rxs_cap_dw;
  fpsr_lvl_t rxd_size;
  logic rxd_full;
  logic move_tx;
  logic move_rx;
  logic rx_word;
  logic frame_drop;
  logic rxm_room;
  logic word_lost;
  logic rx_eof_take;
  logic phy_run;
  logic software_reset_request_apply;
  logic software_reset_request_timeout;
  logic wr_ok;
  logic [`FPSR_INT_W-1:0] int_evt;
  fpsr_word_t rd_mux;

  // Partition arithmetic follows the selection directly
  assign tx_total = {2'h0, sel_q, 10'h000};
  assign txd_size = tx_total - `FPSR_TXS_BYTES;
  assign txd_free = txd_size - txd_lvl.level;
  assign rx_total = `FPSR_BUF_BYTES - tx_total;
  assign rxs_size = {4'h0, rx_total[15:4]};
  assign rxs_cap_dw = {2'h0, rxs_size[15:2]};
  assign rxd_size = rx_total - rxs_size;
  assign rxd_full = rxd_lvl.level >= (rxd_size - `FPSR_RX_FULL_MARGIN);

  // Transmit path; staging refills every cycle it has a free dword
  assign move_tx = (txd_lvl.level >= `FPSR_DW_BYTES) &&
                   (txm_lvl.level <= (`FPSR_TXM_BYTES - `FPSR_DW_BYTES));
  assign txd_lvl.inc = HOST_TXD_WR_I && (txd_free >= `FPSR_DW_BYTES);
  assign txd_lvl.dec = move_tx;
  assign txm_lvl.inc = move_tx;
  assign txm_lvl.dec = MAC_TX_RD_I && mac_ctl_q[`FPSR_MACCTL_TXEN] && (txm_lvl.level >= `FPSR_DW_BYTES);
  assign txs_lvl.inc = MAC_TX_STS_I && (txs_lvl.level < `FPSR_TXS_DW);
  assign txs_lvl.dec = HOST_TXS_RD_I && (txs_lvl.level != 16'h0000);

  // Receive path; a frame starting while still dropping is lost whole if the FIFO stays full
  assign rx_word = MAC_RX_WR_I && mac_ctl_q[`FPSR_MACCTL_RXEN];
  assign frame_drop = sof_q ? (dropping_q && rxd_full) : frame_lost_q;
  assign rxm_room = rxm_lvl.level <= (`FPSR_RXM_BYTES - `FPSR_DW_BYTES);
  assign word_lost = frame_drop || !rxm_room;
  assign rx_eof_take = rx_word && MAC_RX_EOF_I && !word_lost;
  assign move_rx = (rxm_lvl.level >= `FPSR_DW_BYTES) && !rxd_full;
  assign rxm_lvl.inc = rx_word && !word_lost;
  assign rxm_lvl.dec = move_rx;
  assign rxd_lvl.inc = move_rx;
  assign rxd_lvl.dec = HOST_RXD_RD_I && (rxd_lvl.level >= `FPSR_DW_BYTES);
  assign rxs_lvl.inc = rx_eof_take && (rxs_lvl.level < rxs_cap_dw);
  assign rxs_lvl.dec = HOST_RXS_RD_I && (rxs_lvl.level != 16'h0000);

  assign txd_lvl.clr = software_reset_request_apply;
  assign txs_lvl.clr = software_reset_request_apply;
  assign txm_lvl.clr = software_reset_request_apply;
  assign rxd_lvl.clr = software_reset_request_apply;
  assign rxs_lvl.clr = software_reset_request_apply;
  assign rxm_lvl.clr = software_reset_request_apply;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || software_reset_request_apply) begin
      sof_q <= 1'b1;
      frame_lost_q <= 1'b0;
      dropping_q <= 1'b0;
    end else if (rx_word) begin
      sof_q <= MAC_RX_EOF_I;
      frame_lost_q <= MAC_RX_EOF_I ? 1'b0 : word_lost;
      if (!rxm_room && !frame_drop) begin
        dropping_q <= 1'b1;
      end else if (sof_q && !rxd_full) begin
        dropping_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || software_reset_request_apply) begin
      drop_cnt_q <= 16'h0000;
    end else if (rx_word && MAC_RX_EOF_I && word_lost) begin
      drop_cnt_q <= drop_cnt_q + 16'h0001;
    end
  end

  // PHY clock activity, judged from the synchronised pins
  for (genvar i = 0; i < 2; i++) begin : g_phy
    always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
        clk_prev_q[i] <= 1'b0;
        idle_cnt_q[i] <= 6'(`FPSR_PHY_IDLE_CYC);
      end else begin
        clk_prev_q[i] <= pin_sync[i];
        if (pin_sync[i] != clk_prev_q[i]) begin
          idle_cnt_q[i] <= 6'h00;
        end else if (idle_cnt_q[i] < 6'(`FPSR_PHY_IDLE_CYC)) begin
          idle_cnt_q[i] <= idle_cnt_q[i] + 6'h01;
        end
      end
    end
  end
  assign phy_run = (idle_cnt_q[0] < 6'(`FPSR_PHY_IDLE_CYC)) && (idle_cnt_q[1] < 6'(`FPSR_PHY_IDLE_CYC));

  // Soft reset sequencer
  assign software_reset_request_apply = (software_reset_request_state_q == SOFTWARE_RESET_REQUEST_WAIT) && phy_run &&
                      (software_reset_request_cnt_q >= 12'(`FPSR_SOFTWARE_RESET_REQUEST_MIN_CYC - 1));
  assign software_reset_request_timeout = (software_reset_request_state_q == SOFTWARE_RESET_REQUEST_WAIT) && !software_reset_request_apply &&
                        (software_reset_request_cnt_q == 12'(`FPSR_SOFTWARE_RESET_REQUEST_TIMEOUT_CYC - 1));
  assign wr_ok = WR_I && armed_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      software_reset_request_state_q <= SOFTWARE_RESET_REQUEST_IDLE;
      software_reset_request_cnt_q <= 12'h000;
    end else begin
      case (software_reset_request_state_q)
        SOFTWARE_RESET_REQUEST_IDLE: begin
          software_reset_request_cnt_q <= 12'h000;
          if (wr_ok && (ADDR_I == `FPSR_REG_HARDWARE_CONFIGURATION) && WDATA_I[`FPSR_HWC_SOFTWARE_RESET_REQUEST]) begin
            software_reset_request_state_q <= SOFTWARE_RESET_REQUEST_WAIT;
          end
        end
        SOFTWARE_RESET_REQUEST_WAIT: begin
          software_reset_request_cnt_q <= software_reset_request_cnt_q + 12'h001;
          if (software_reset_request_apply || software_reset_request_timeout) begin
            software_reset_request_state_q <= SOFTWARE_RESET_REQUEST_IDLE;
          end
        end
        default: begin
          software_reset_request_state_q <= SOFTWARE_RESET_REQUEST_IDLE;
        end
      endcase
    end
  end

  // A retry clears the flag; the flag itself survives soft reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      timeout_flag_q <= 1'b0;
    end else if (software_reset_request_timeout) begin
      timeout_flag_q <= 1'b1;
    end else if (wr_ok && (ADDR_I == `FPSR_REG_HARDWARE_CONFIGURATION) && WDATA_I[`FPSR_HWC_SOFTWARE_RESET_REQUEST] &&
                 (software_reset_request_state_q == SOFTWARE_RESET_REQUEST_IDLE)) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // Strap is caught once the synchroniser has filled after reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      strap_wait_q <= 2'h0;
      strap_q <= 1'b0;
    end else if (strap_wait_q != 2'h3) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_q <= pin_sync[2];
    end
  end

  // Writes are ignored until the first read after either reset
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || software_reset_request_apply) begin
      armed_q <= 1'b0;
    end else if (RD_I) begin
      armed_q <= 1'b1;
    end
  end

  // Selection survives soft reset; reserved encodings are ignored
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      sel_q <= `FPSR_SEL_RST;
    end else if (wr_ok && (ADDR_I == `FPSR_REG_HARDWARE_CONFIGURATION) &&
                 (WDATA_I[`FPSR_HWC_SEL_MSB:`FPSR_HWC_SEL_LSB] >= `FPSR_SEL_MIN) &&
                 (WDATA_I[`FPSR_HWC_SEL_MSB:`FPSR_HWC_SEL_LSB] <= `FPSR_SEL_MAX)) begin
      sel_q <= WDATA_I[`FPSR_HWC_SEL_MSB:`FPSR_HWC_SEL_LSB];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || software_reset_request_apply) begin
      mac_ctl_q <= `FPSR_MACCTL_RST;
      int_en_q <= 4'h0;
    end else if (wr_ok && (ADDR_I == `FPSR_REG_MAC_CTL)) begin
      mac_ctl_q <= WDATA_I[1:0];
    end else if (wr_ok && (ADDR_I == `FPSR_REG_INT_EN)) begin
      int_en_q <= WDATA_I[`FPSR_INT_W-1:0];
    end
  end

  // Sticky events; a new event beats a same-cycle write-one-to-clear
  assign int_evt[`FPSR_INT_RXDROP] = rx_word && MAC_RX_EOF_I && word_lost;
  assign int_evt[`FPSR_INT_SRSTTO] = software_reset_request_timeout;
  assign int_evt[`FPSR_INT_RXSTS] = rxs_lvl.inc;
  assign int_evt[`FPSR_INT_TXSTS] = txs_lvl.inc;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || software_reset_request_apply) begin
      int_sts_q <= 4'h0;
    end else if (wr_ok && (ADDR_I == `FPSR_REG_INT_STS)) begin
      int_sts_q <= (int_sts_q & ~WDATA_I[`FPSR_INT_W-1:0]) | int_evt;
    end else begin
      int_sts_q <= int_sts_q | int_evt;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
      RX_FULL_O <= 1'b0;
      MAC_TX_VALID_O <= 1'b0;
    end else begin
      IRQ_O <= |(int_sts_q & int_en_q);
      RX_FULL_O <= rxd_full;
      MAC_TX_VALID_O <= mac_ctl_q[`FPSR_MACCTL_TXEN] && (txm_lvl.level >= `FPSR_DW_BYTES);
    end
  end

  // Read mux; staging levels never appear here
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ADDR_I == `FPSR_REG_HARDWARE_CONFIGURATION) begin
      rd_mux[`FPSR_HWC_SEL_MSB:`FPSR_HWC_SEL_LSB] = sel_q;
      rd_mux[`FPSR_HWC_STRAP] = strap_q;
      rd_mux[`FPSR_HWC_TIMEOUT] = timeout_flag_q;
      rd_mux[`FPSR_HWC_SOFTWARE_RESET_REQUEST] = (software_reset_request_state_q == SOFTWARE_RESET_REQUEST_WAIT);
    end else if (ADDR_I == `FPSR_REG_RX_INF) begin
      rd_mux[`FPSR_INF_HI_MSB:`FPSR_INF_HI_LSB] = rxs_lvl.level[7:0];
      rd_mux[15:0] = rxd_lvl.level;
    end else if (ADDR_I == `FPSR_REG_TX_INF) begin
      rd_mux[`FPSR_INF_HI_MSB:`FPSR_INF_HI_LSB] = txs_lvl.level[7:0];
      rd_mux[15:0] = txd_free;
    end else if (ADDR_I == `FPSR_REG_INT_STS) begin
      rd_mux[`FPSR_INT_W-1:0] = int_sts_q;
    end else if (ADDR_I == `FPSR_REG_INT_EN) begin
      rd_mux[`FPSR_INT_W-1:0] = int_en_q;
    end else if (ADDR_I == `FPSR_REG_DROP) begin
      rd_mux[15:0] = drop_cnt_q;
    end else if (ADDR_I == `FPSR_REG_MAC_CTL) begin
      rd_mux[1:0] = mac_ctl_q;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= RD_I ? rd_mux : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  tx_split_ok_a: assert property (txd_size + `FPSR_TXS_BYTES == {2'h0, sel_q, 10'h000})
    else $error("transmit data size does not match allocation");
  txs_bound_a: assert property (txs_lvl.inc |=> txs_lvl.level <= `FPSR_TXS_DW)
    else $error("transmit status above 128 dwords");
  rx_total_a: assert property (rx_total + tx_total == `FPSR_BUF_BYTES)
    else $error("receive plus transmit not 16384");
  rxs_ratio_a: assert property ({rxs_size[11:0], 4'h0} + rx_total[3:0] == rx_total && rxd_size + rxs_size == rx_total)
    else $error("receive status not one sixteenth");
  rx_full_out_a: assert property ($rose(RX_FULL_O) |-> $past(rxd_lvl.level) >= $past(rxd_size) - `FPSR_RX_FULL_MARGIN)
    else $error("receive full raised too early");
  stage_cap_a: assert property (txm_lvl.level <= `FPSR_TXM_BYTES && rxm_lvl.level <= `FPSR_RXM_BYTES)
    else $error("staging buffer over capacity");
  tx_refill_a: assert property ((move_tx && !txm_lvl.dec && !software_reset_request_apply) |=> txm_lvl.level == $past(txm_lvl.level) + `FPSR_DW_BYTES)
    else $error("transmit staging not refilled");
  rx_hold_a: assert property ((rxd_full && !rx_word && !HOST_RXD_RD_I && !software_reset_request_apply) |=> rxm_lvl.level == $past(rxm_lvl.level))
    else $error("receive staging drained into full FIFO");
  drop_count_a: assert property ((int_evt[`FPSR_INT_RXDROP] && !software_reset_request_apply) |=> drop_cnt_q == $past(drop_cnt_q) + 16'h0001)
    else $error("lost frame not counted");
  rx_inf_a: assert property ((RD_I && ADDR_I == `FPSR_REG_RX_INF) |=> RDATA_O[15:0] == $past(rxd_lvl.level))
    else $error("receive used space includes staging");
  strap_read_a: assert property ((RD_I && ADDR_I == `FPSR_REG_HARDWARE_CONFIGURATION) |=> RDATA_O[`FPSR_HWC_STRAP] == $past(strap_q))
    else $error("bus width bit wrong");
  software_reset_request_timeout_a: assert property (software_reset_request_timeout |=> timeout_flag_q && software_reset_request_state_q == SOFTWARE_RESET_REQUEST_IDLE && int_sts_q[`FPSR_INT_SRSTTO])
    else $error("soft reset timeout not flagged");
  software_reset_request_done_a: assert property (software_reset_request_apply |=> software_reset_request_state_q == SOFTWARE_RESET_REQUEST_IDLE && rxd_lvl.level == 16'h0000 && mac_ctl_q == `FPSR_MACCTL_RST)
    else $error("soft reset did not clear");
  write_arm_a: assert property ((!armed_q && WR_I && !software_reset_request_apply) |=> $stable(int_en_q) && $stable(mac_ctl_q))
    else $error("write taken before first read");

  drop_seen_c: cover property (int_evt[`FPSR_INT_RXDROP]);
  timeout_seen_c: cover property (software_reset_request_timeout);
  reset_done_c: cover property (software_reset_request_apply);
  rx_full_c: cover property (rxd_full && rx_word);
endmodule
`default_nettype wire

// ==== verif/fpsr_mac_model.sv ====
/*
  Behavioural MAC and PHY clock source standing on the far side of the partition block.
  Assumes the bench calls its tasks from one process at a time, on the system clock.
*/
`default_nettype none
module fpsr_mac_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic tx_take_i,
  input wire logic phy_run_i,
  // Block side
  input wire logic tx_valid_i,
  output logic tx_rd_o,
  output logic tx_sts_o,
  output logic rx_wr_o,
  output logic rx_eof_o,
  output logic phy_rx_clk_o,
  output logic phy_tx_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tx_rd_o = 1'b0;
    tx_sts_o = 1'b0;
    rx_wr_o = 1'b0;
    rx_eof_o = 1'b0;
    phy_rx_clk_o = 1'b0;
    phy_tx_clk_o = 1'b0;
  end
  // Stopped PHY clocks stand still, so the block must see them as dead
  always begin
    #20;
    if (phy_run_i) begin
      phy_rx_clk_o = ~phy_rx_clk_o;
      phy_tx_clk_o = ~phy_tx_clk_o;
    end
  end
  // Every other cycle at most, because valid lags the staging level by one
  always @(posedge clk_i) begin
    tx_rd_o <= !rst_i && tx_take_i && tx_valid_i && !tx_rd_o;
  end
  task automatic send_frame(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_wr_o <= 1'b1;
      rx_eof_o <= (i == n - 1);
    end
    @(posedge clk_i);
    rx_wr_o <= 1'b0;
    rx_eof_o <= 1'b0;
  endtask
  task automatic push_status();
    @(posedge clk_i);
    tx_sts_o <= 1'b1;
    @(posedge clk_i);
    tx_sts_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/fifo_partition_and_soft_reset_test.sv ====
/*
  Self-checking bench: partition sizes, staging, overrun dropping, interrupts, soft reset.
  Assumes the MAC model on the far side and a 100 MHz clock.
*/
`include "fpsr_consts.svh"
`default_nettype none
module fifo_partition_and_soft_reset_test import fpsr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tx_take = 1'b0;
  logic phy_run = 1'b1;
  logic strap = 1'b0;
  logic [3:0] hst = 4'h0;
  fpsr_addr_t addr = 8'h00;
  fpsr_word_t wdata = 32'h0;
  fpsr_word_t rdata, rv;
  logic mtx_rd, mtx_sts, mrx_wr, mrx_eof, tx_valid, rx_full, irq, prx, ptx;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 34;
  int sel;
  int exp_sel = 5;
  fpsr_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .HOST_TXD_WR_I(hst[0]), .HOST_TXS_RD_I(hst[1]), .HOST_RXD_RD_I(hst[2]),
    .HOST_RXS_RD_I(hst[3]), .MAC_TX_RD_I(mtx_rd), .MAC_TX_STS_I(mtx_sts), .MAC_RX_WR_I(mrx_wr),
    .MAC_RX_EOF_I(mrx_eof), .MAC_TX_VALID_O(tx_valid), .PHY_RX_CLK_I(prx), .PHY_TX_CLK_I(ptx),
    .BUS_WIDTH_STRAP_I(strap), .RX_FULL_O(rx_full), .IRQ_O(irq));
  fpsr_mac_model mac_u (.clk_i(clk), .rst_i(rst), .tx_take_i(tx_take), .phy_run_i(phy_run),
    .tx_valid_i(tx_valid), .tx_rd_o(mtx_rd), .tx_sts_o(mtx_sts), .rx_wr_o(mrx_wr), .rx_eof_o(mrx_eof),
    .phy_rx_clk_o(prx), .phy_tx_clk_o(ptx));
  always #5 clk = ~clk;
  task automatic give_verdict();
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short; the whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input fpsr_word_t got, input fpsr_word_t exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input fpsr_addr_t a, input fpsr_word_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input fpsr_addr_t a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic pulse(input int b, input int n);
    @(posedge clk);
    hst[b] <= 1'b1;
    repeat (n) @(posedge clk);
    hst[b] <= 1'b0;
  endtask
  function automatic int txd(input int s);
    return s * 1024 - 512;
  endfunction
  function automatic int rxd(input int s);
    return (16384 - s * 1024) - (16384 - s * 1024) / 16;
  endfunction
  function automatic fpsr_word_t cfg(input int s);
    return {12'h000, 4'(s), 13'h0000, strap, 2'b00};
  endfunction
  initial begin
    strap = 1'($random(seed));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr_reg(`FPSR_REG_HARDWARE_CONFIGURATION, 32'h0008_0000);
    repeat (4) @(posedge clk);
    rd_reg(`FPSR_REG_HARDWARE_CONFIGURATION);
    check(rv & 32'h000F_0007, cfg(5));
    rd_reg(8'h00);
    check(rv, 32'h0);
    rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'h0000_1200);
    // Every legal select, then random ones that may be reserved
    for (int i = 0; i < 19; i++) begin
      sel = (i < 13) ? i + 2 : ($random(seed) & 15);
      wr_reg(`FPSR_REG_HARDWARE_CONFIGURATION, cfg(sel) ^ 32'h4);
      if (sel >= 2 && sel <= 14) exp_sel = sel;
      rd_reg(`FPSR_REG_HARDWARE_CONFIGURATION);
      check(rv & 32'h000F_0007, cfg(exp_sel));
      rd_reg(`FPSR_REG_TX_INF);
      check(rv, 32'(txd(exp_sel)));
    end
    wr_reg(`FPSR_REG_HARDWARE_CONFIGURATION, cfg(14));
    wr_reg(`FPSR_REG_MAC_CTL, 32'h3);
    wr_reg(`FPSR_REG_INT_EN, 32'h1);
    pulse(0, 520);
    repeat (10) @(posedge clk);
    rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'(txd(14) - 32));
    check({31'h0, tx_valid}, 32'h1);
    tx_take <= 1'b1;
    for (int k = 0; k < 200 && rv !== 32'(txd(14)); k++) rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'(txd(14)));
    tx_take <= 1'b0;
    mac_u.push_status();
    rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'h0001_0000 | 32'(txd(14)));
    pulse(1, 1);
    rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'(txd(14)));
    // Fill the receive side frame by frame across the full threshold
    rd_reg(`FPSR_REG_RX_INF);
    check(rv, 32'h0);
    for (int f = 0; f < 40 && rv[15:0] < 16'(rxd(14) - 16); f++) begin
      mac_u.send_frame(16);
      repeat (40) @(posedge clk);
      rd_reg(`FPSR_REG_RX_INF);
      check({31'h0, rx_full}, {31'h0, 1'(int'(rv[15:0]) >= rxd(14) - 16)});
      check(32'(rv[23:16]), 32'(f + 1));
    end
    repeat (3) mac_u.send_frame(40);
    repeat (40) @(posedge clk);
    rd_reg(`FPSR_REG_DROP);
    check(rv, 32'h3);
    rd_reg(`FPSR_REG_RX_INF);
    check(32'(rv[23:16]), 32'd30);
    check({31'h0, 1'(int'(rv[15:0]) <= rxd(14))}, 32'h1);
    check({31'h0, irq}, 32'h1);
    rd_reg(`FPSR_REG_INT_STS);
    check(rv, 32'hD);
    wr_reg(`FPSR_REG_INT_EN, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    wr_reg(`FPSR_REG_INT_STS, 32'hF);
    wr_reg(`FPSR_REG_INT_EN, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    pulse(2, 200);
    pulse(3, 30);
    repeat (40) @(posedge clk);
    mac_u.send_frame(16);
    repeat (40) @(posedge clk);
    rd_reg(`FPSR_REG_RX_INF);
    check(32'(rv[23:16]), 32'd1);
    check(32'(rv[15:0]), 32'(rxd(14) - 16 + 128 - 800 + 64));
    rd_reg(`FPSR_REG_DROP);
    check(rv, 32'h3);
    // Soft reset with dead PHY clocks must time out, then succeed once they run
    phy_run <= 1'b0;
    repeat (60) @(posedge clk);
    wr_reg(`FPSR_REG_HARDWARE_CONFIGURATION, cfg(14) | 32'h1);
    rd_reg(`FPSR_REG_HARDWARE_CONFIGURATION);
    check(rv & 32'h3, 32'h1);
    repeat (1010) @(posedge clk);
    rd_reg(`FPSR_REG_HARDWARE_CONFIGURATION);
    check(rv & 32'h3, 32'h2);
    rd_reg(`FPSR_REG_INT_STS);
    check(rv, 32'h6);
    phy_run <= 1'b1;
    repeat (60) @(posedge clk);
    wr_reg(`FPSR_REG_HARDWARE_CONFIGURATION, cfg(14) | 32'h1);
    repeat (100) @(posedge clk);
    wr_reg(`FPSR_REG_MAC_CTL, 32'h3);
    rd_reg(`FPSR_REG_HARDWARE_CONFIGURATION);
    check(rv & 32'h000F_0007, cfg(14));
    rd_reg(`FPSR_REG_DROP);
    check(rv, 32'h0);
    rd_reg(`FPSR_REG_TX_INF);
    check(rv, 32'(txd(14)));
    rd_reg(`FPSR_REG_MAC_CTL);
    check(rv, 32'h0);
    check({31'h0, tx_valid}, 32'h0);
    check({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
